// ### hdl/counter_array_regs.vh
// register offsets, field positions, reset values and timing for the counter array
// assumes an 8-bit special function register space addressed by an 8-bit offset
`ifndef COUNTER_ARRAY_REGS_VH
`define COUNTER_ARRAY_REGS_VH

`define CA_CHANNELS            6
`define CA_WATCHDOG_CHANNEL    5

// special function register offsets
`define CA_ADDR_CONTROL        8'hD8
`define CA_ADDR_PULSE_CONFIG   8'hDF
`define CA_ADDR_MODE0          8'hDA
`define CA_ADDR_MODE1          8'hDB
`define CA_ADDR_MODE2          8'hDC
`define CA_ADDR_MODE3          8'hDD
`define CA_ADDR_MODE4          8'hDE
`define CA_ADDR_MODE5          8'hCE
`define CA_ADDR_CMP_LOW0       8'hFB
`define CA_ADDR_CMP_HIGH0      8'hFC
`define CA_ADDR_CMP_LOW1       8'hE9
`define CA_ADDR_CMP_HIGH1      8'hEA
`define CA_ADDR_CMP_LOW2       8'hEB
`define CA_ADDR_CMP_HIGH2      8'hEC
`define CA_ADDR_CMP_LOW3       8'hED
`define CA_ADDR_CMP_HIGH3      8'hEE
`define CA_ADDR_CMP_LOW4       8'hFD
`define CA_ADDR_CMP_HIGH4      8'hFE
`define CA_ADDR_CMP_LOW5       8'hD2
`define CA_ADDR_CMP_HIGH5      8'hD3
`define CA_ADDR_COUNT_LOW      8'hF9
`define CA_ADDR_COUNT_HIGH     8'hFA

// module_mode_register fields
`define CA_MODE_WIDE           7
`define CA_MODE_COMPARE        6
`define CA_MODE_RISE_CAP       5
`define CA_MODE_FALL_CAP       4
`define CA_MODE_MATCH          3
`define CA_MODE_TOGGLE         2
`define CA_MODE_PULSE          1
`define CA_MODE_IRQ            0

// control register fields
`define CA_CTRL_OVERFLOW       7
`define CA_CTRL_RUN            6

// pulse_config_register fields
`define CA_PCFG_BANK           7
`define CA_PCFG_COV_IRQ        6
`define CA_PCFG_COV_FLAG       5
`define CA_PCFG_CYCLE_HI       1
`define CA_PCFG_CYCLE_LO       0

// reset values
`define CA_RESET_BYTE          8'h00
`define CA_RESET_WORD          16'h0000
`define CA_RESET_CYCLE         2'h0

// cycle_length_field codes
`define CA_CYCLE_8             2'h0
`define CA_CYCLE_9             2'h1
`define CA_CYCLE_10            2'h2
`define CA_CYCLE_11            2'h3

`endif

// ### hdl/compare_channel.v
// one capture/compare module: value, reload value, capture, match and waveform
// assumes synchronised pin input and a one-cycle count_step pulse after each count
`timescale 1ns/1ps
`default_nettype none
`include "counter_array_regs.vh"

module compare_channel (
    input  wire        clk,
    input  wire        nrst,
    input  wire [7:0]  mode,
    input  wire [15:0] counter,
    input  wire        count_step,
    input  wire [1:0]  cycle_length_field,
    input  wire        pin_sync,
    input  wire        reload_bank_select,
    input  wire        wr_low,
    input  wire        wr_high,
    input  wire [7:0]  wdata,
    output reg  [15:0] value_q,
    output reg  [15:0] reload_q,
    output reg         pin_out_q,
    output wire        event_pulse
);
    reg         pin_last_q;
    reg  [15:0] mask;
    reg  [15:0] value_d;
    wire        pwm_mode   = mode[`CA_MODE_PULSE];
    wire        tog_mode   = mode[`CA_MODE_TOGGLE];
    wire        wide_mode  = mode[`CA_MODE_WIDE] & pwm_mode;                 // [R1]
    wire        freq_mode  = tog_mode & pwm_mode;                            // [R7]
    wire        rise       = pin_sync & ~pin_last_q & mode[`CA_MODE_RISE_CAP]; // [R3]
    wire        fall       = ~pin_sync & pin_last_q & mode[`CA_MODE_FALL_CAP]; // [R4]
    wire        capture    = rise | fall;
    wire        match_full = (counter == value_q);
    wire        match_low  = (counter[7:0] == value_q[7:0]);
    wire        cyc_wrap   = ((counter & mask) == `CA_RESET_WORD);
    wire        match;

    always @* begin
        mask = (16'h0100 << cycle_length_field) - 16'h0001;                 // [R18]
    end

    // frequency output matches on the low byte only
    assign match = count_step & mode[`CA_MODE_COMPARE]                       // [R2]
                 & (freq_mode ? match_low : match_full);
    // flag on match when enabled, always on capture
    assign event_pulse = capture | (match & mode[`CA_MODE_MATCH]);           // [R5]

    always @* begin
        value_d = value_q;
        if (capture) begin
            value_d = counter;
        end else if (freq_mode & match) begin
            value_d[7:0] = value_q[7:0] + value_q[15:8];
        end else if (pwm_mode & ~wide_mode & count_step & cyc_wrap) begin
            // short cycles reload at wrap; 8-bit from the high byte
            if (cycle_length_field == `CA_CYCLE_8) begin
                value_d[7:0] = value_q[15:8];
            end else begin
                value_d = (value_q & ~mask) | (reload_q & mask);             // [R14]
            end
        end
        if (~reload_bank_select & wr_low) begin
            value_d[7:0] = wdata;
        end
        if (~reload_bank_select & wr_high) begin
            value_d[15:8] = wdata;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            value_q    <= `CA_RESET_WORD;                                    // [R20]
            reload_q   <= `CA_RESET_WORD;
            pin_out_q  <= 1'b0;
            pin_last_q <= 1'b0;
        end else begin
            pin_last_q <= pin_sync;
            value_q    <= value_d;
            if (reload_bank_select & wr_low) begin                           // [R17]
                reload_q[7:0] <= wdata;
            end
            if (reload_bank_select & wr_high) begin
                reload_q[15:8] <= wdata;
            end
            if (match & tog_mode) begin
                pin_out_q <= ~pin_out_q;                                     // [R6]
            end else if (pwm_mode & ~tog_mode) begin
                // output high from match to the end of the cycle
                if (wide_mode) begin
                    pin_out_q <= mode[`CA_MODE_COMPARE] & (counter >= value_q);   // [R8]
                end else begin
                    pin_out_q <= mode[`CA_MODE_COMPARE] & ((counter & mask) >= (value_q & mask)); // [R8]
                end
            end
        end
    end
endmodule

`default_nettype wire

// ### hdl/counter_array.v
// counter array: 16-bit counter, six capture/compare modules and their registers
// assumes a single-cycle special function register port from the processor and
// a count_tick pulse from the timebase selector on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "counter_array_regs.vh"

// Functional notes
// R1 - mode bit 7 picks 16-bit pulse width
// R2 - mode bit 6 enables comparator
// R3 - mode bit 5 captures on rising edge
// R4 - mode bit 4 captures on falling edge
// R5 - mode bit 3 sets flag on match
// R6 - mode bit 2 toggles pin on match
// R7 - toggle plus pulse width gives frequency output
// R8 - mode bit 1 drives pulse width waveform
// R9 - mode bit 0 gates flag interrupt request
// R10 - watchdog blocks module 5 mode writes
// R11 - watchdog blocks counter low byte writes
// R12 - watchdog blocks counter high byte writes
// R13 - high byte reads snapshot taken on low read
// R14 - shared addresses reach auto-reload values
// R15 - compare low write clears comparator enable
// R16 - compare high write sets comparator enable
// R17 - bank select: zero normal, one reload
// R18 - two-bit field sets cycle 8 to 11
// R19 - hardware sets flags, software clears them
// R20 - all registers reset to zero
module counter_array (
    input  wire        clk,
    input  wire        nrst,
    input  wire [7:0]  sfr_addr,
    input  wire [7:0]  sfr_wdata,
    input  wire        sfr_we,
    input  wire        sfr_re,
    output reg  [7:0]  sfr_rdata,
    input  wire        count_tick,
    input  wire        watchdog_enable,
    input  wire [5:0]  module_io_pin_in,
    output wire [5:0]  module_io_pin_out,
    output wire [5:0]  module_io_pin_oe_n,
    output wire        irq_request
);
    // decoders shared by write and read paths; 7 means no match
    function [2:0] low_index;
        input [7:0] a;
        begin
            case (a)
                `CA_ADDR_CMP_LOW0: low_index = 3'h0;
                `CA_ADDR_CMP_LOW1: low_index = 3'h1;
                `CA_ADDR_CMP_LOW2: low_index = 3'h2;
                `CA_ADDR_CMP_LOW3: low_index = 3'h3;
                `CA_ADDR_CMP_LOW4: low_index = 3'h4;
                `CA_ADDR_CMP_LOW5: low_index = 3'h5;
                default:           low_index = 3'h7;
            endcase
        end
    endfunction

    function [2:0] high_index;
        input [7:0] a;
        begin
            case (a)
                `CA_ADDR_CMP_HIGH0: high_index = 3'h0;
                `CA_ADDR_CMP_HIGH1: high_index = 3'h1;
                `CA_ADDR_CMP_HIGH2: high_index = 3'h2;
                `CA_ADDR_CMP_HIGH3: high_index = 3'h3;
                `CA_ADDR_CMP_HIGH4: high_index = 3'h4;
                `CA_ADDR_CMP_HIGH5: high_index = 3'h5;
                default:            high_index = 3'h7;
            endcase
        end
    endfunction

    function [2:0] mode_index;
        input [7:0] a;
        begin
            case (a)
                `CA_ADDR_MODE0: mode_index = 3'h0;
                `CA_ADDR_MODE1: mode_index = 3'h1;
                `CA_ADDR_MODE2: mode_index = 3'h2;
                `CA_ADDR_MODE3: mode_index = 3'h3;
                `CA_ADDR_MODE4: mode_index = 3'h4;
                `CA_ADDR_MODE5: mode_index = 3'h5;
                default:        mode_index = 3'h7;
            endcase
        end
    endfunction

    reg  [47:0] mode_q;
    reg  [15:0] counter_q;
    reg  [7:0]  snapshot_q;
    reg  [5:0]  event_flag_q;
    reg         overflow_flag_q;
    reg         run_q;
    reg         reload_bank_select_q;
    reg         cov_irq_q;
    reg         cov_flag_q;
    reg  [1:0]  cycle_length_field_q;
    reg         count_step_q;
    reg  [5:0]  pin_meta_q;
    reg  [5:0]  pin_sync_q;
    wire [95:0] value_bus;
    wire [95:0] reload_bus;
    wire [5:0]  event_bus;
    wire [5:0]  irq_enable;
    wire [5:0]  wr_low;
    wire [5:0]  wr_high;
    wire [2:0]  rd_low_idx  = low_index(sfr_addr);
    wire [2:0]  rd_high_idx = high_index(sfr_addr);
    wire [2:0]  rd_mode_idx = mode_index(sfr_addr);
    wire        step        = run_q & count_tick;
    wire [16:0] counter_inc = {1'b0, counter_q} + 17'h00001;
    reg  [15:0] cov_bit;
    reg  [7:0]  rdata_d;

    // pins come from outside; two flops before anything reads them
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_q <= 6'h00;
            pin_sync_q <= 6'h00;
        end else begin
            pin_meta_q <= module_io_pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // bit whose carry out marks the end of a short cycle
    always @* begin
        case (cycle_length_field_q)                                          // [R18]
            `CA_CYCLE_8:  cov_bit = 16'h00FF;
            `CA_CYCLE_9:  cov_bit = 16'h01FF;
            `CA_CYCLE_10: cov_bit = 16'h03FF;
            `CA_CYCLE_11: cov_bit = 16'h07FF;
            default:      cov_bit = 16'h00FF;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < `CA_CHANNELS; g = g + 1) begin : chan
            assign wr_low[g]     = sfr_we & (rd_low_idx == g);
            assign wr_high[g]    = sfr_we & (rd_high_idx == g);
            assign irq_enable[g] = mode_q[8*g + `CA_MODE_IRQ];
            compare_channel u_channel (
                .clk                (clk),
                .nrst               (nrst),
                .mode               (mode_q[8*g +: 8]),
                .counter            (counter_q),
                .count_step         (count_step_q),
                .cycle_length_field (cycle_length_field_q),
                .pin_sync           (pin_sync_q[g]),
                .reload_bank_select (reload_bank_select_q),
                .wr_low             (wr_low[g]),
                .wr_high            (wr_high[g]),
                .wdata              (sfr_wdata),
                .value_q            (value_bus[16*g +: 16]),
                .reload_q           (reload_bus[16*g +: 16]),
                .pin_out_q          (module_io_pin_out[g]),
                .event_pulse        (event_bus[g])
            );
            // pin is driven only while a waveform mode owns it
            assign module_io_pin_oe_n[g] = ~(mode_q[8*g + `CA_MODE_TOGGLE] | mode_q[8*g + `CA_MODE_PULSE]);
        end
    endgenerate

    // mode registers with compare-enable side effects of byte writes
    integer m;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= 48'h000000000000;                                      // [R20]
        end else begin
            for (m = 0; m < `CA_CHANNELS; m = m + 1) begin
                if (sfr_we && rd_mode_idx == m
                    && !(watchdog_enable && m == `CA_WATCHDOG_CHANNEL)) begin // [R10]
                    mode_q[8*m +: 8] <= sfr_wdata;
                end
                if (wr_low[m]) begin
                    mode_q[8*m + `CA_MODE_COMPARE] <= 1'b0;                 // [R15]
                end
                if (wr_high[m]) begin
                    mode_q[8*m + `CA_MODE_COMPARE] <= 1'b1;                 // [R16]
                end
            end
        end
    end

    // counter, snapshot and flags
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            counter_q            <= `CA_RESET_WORD;                          // [R20]
            snapshot_q           <= `CA_RESET_BYTE;
            event_flag_q         <= 6'h00;
            overflow_flag_q      <= 1'b0;
            run_q                <= 1'b0;
            reload_bank_select_q <= 1'b0;
            cov_irq_q            <= 1'b0;
            cov_flag_q           <= 1'b0;
            cycle_length_field_q <= `CA_RESET_CYCLE;
            count_step_q         <= 1'b0;
        end else begin
            // channels compare one cycle after the counter moves
            count_step_q <= step;
            if (step) begin
                counter_q <= counter_inc[15:0];
            end
            if (sfr_we && sfr_addr == `CA_ADDR_COUNT_LOW && !watchdog_enable) begin  // [R11]
                counter_q[7:0] <= sfr_wdata;
            end
            if (sfr_we && sfr_addr == `CA_ADDR_COUNT_HIGH && !watchdog_enable) begin // [R12]
                counter_q[15:8] <= sfr_wdata;
            end
            if (sfr_re && sfr_addr == `CA_ADDR_COUNT_LOW) begin
                snapshot_q <= counter_q[15:8];                               // [R13]
            end
            // software write first, hardware set after so a set wins
            if (sfr_we && sfr_addr == `CA_ADDR_CONTROL) begin
                event_flag_q    <= sfr_wdata[5:0];
                overflow_flag_q <= sfr_wdata[`CA_CTRL_OVERFLOW];
                run_q           <= sfr_wdata[`CA_CTRL_RUN];
            end
            if (sfr_we && sfr_addr == `CA_ADDR_PULSE_CONFIG) begin
                reload_bank_select_q <= sfr_wdata[`CA_PCFG_BANK];            // [R17]
                cov_irq_q            <= sfr_wdata[`CA_PCFG_COV_IRQ];
                cov_flag_q           <= sfr_wdata[`CA_PCFG_COV_FLAG];
                cycle_length_field_q <= sfr_wdata[`CA_PCFG_CYCLE_HI:`CA_PCFG_CYCLE_LO];
            end
            if (|event_bus) begin
                event_flag_q <= ((sfr_we && sfr_addr == `CA_ADDR_CONTROL)    // [R19]
                                 ? sfr_wdata[5:0]
                                 : event_flag_q)
                                | event_bus;
            end
            if (step && counter_q == 16'hFFFF) begin
                overflow_flag_q <= 1'b1;
            end
            if (step && (counter_q & cov_bit) == cov_bit) begin
                cov_flag_q <= 1'b1;
            end
        end
    end

    // overflow enable lives outside; module flags and cycle overflow flag gated
    assign irq_request = |(event_flag_q & irq_enable)                        // [R9]
                       | (cov_flag_q & cov_irq_q);

    // read data registered, one cycle after the strobe
    always @* begin
        rdata_d = `CA_RESET_BYTE;
        if (rd_mode_idx != 3'h7) begin
            rdata_d = mode_q[8*rd_mode_idx +: 8];
        end else if (rd_low_idx != 3'h7) begin
            rdata_d = reload_bank_select_q ? reload_bus[16*rd_low_idx +: 8]  // [R14]
                                           : value_bus[16*rd_low_idx +: 8];
        end else if (rd_high_idx != 3'h7) begin
            rdata_d = reload_bank_select_q ? reload_bus[16*rd_high_idx + 8 +: 8]
                                           : value_bus[16*rd_high_idx + 8 +: 8];
        end else begin
            case (sfr_addr)
                `CA_ADDR_COUNT_LOW:    rdata_d = counter_q[7:0];
                `CA_ADDR_COUNT_HIGH:   rdata_d = snapshot_q;                 // [R13]
                `CA_ADDR_CONTROL:      rdata_d = {overflow_flag_q, run_q, event_flag_q};
                `CA_ADDR_PULSE_CONFIG: rdata_d = {reload_bank_select_q, cov_irq_q, cov_flag_q,
                                                  3'h0, cycle_length_field_q};
                default:               rdata_d = `CA_RESET_BYTE;
            endcase
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= `CA_RESET_BYTE;
        end else if (sfr_re) begin
            sfr_rdata <= rdata_d;
        end
    end
endmodule

`default_nettype wire

// ### sim/capture_pins.sv
// far side of the counter array: capture input drivers
// assumes the bench changes level_req off the rising edge
`timescale 1ns/1ps
`default_nettype none
module capture_pins (
    input  wire logic       clk,
    input  wire logic [5:0] level_req,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe_n,
    output logic      [5:0] pin_in
);
    logic [5:0] level_q = 6'h00;
    // bench holds each level far beyond the two-clock minimum
    always @(posedge clk) begin
        level_q <= level_req;
    end
    // a driven pin reads back the module's own level
    assign pin_in = (pin_oe_n & level_q) | (~pin_oe_n & pin_out);
endmodule
`default_nettype wire

// ### sim/counter_array_props.sv
// assertions on the counter array register port and pins
// assumes one-cycle strobes and read data one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module counter_array_props (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_we,
    input wire logic       sfr_re,
    input wire logic [7:0] sfr_rdata,
    input wire logic       count_tick,
    input wire logic       watchdog_enable,
    input wire logic [5:0] module_io_pin_in,
    input wire logic [5:0] module_io_pin_out,
    input wire logic [5:0] module_io_pin_oe_n,
    input wire logic       irq_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_rd(logic [7:0] a);
        sfr_re && sfr_addr == a;
    endsequence
    sequence s_wr(logic [7:0] a);
        sfr_we && sfr_addr == a;
    endsequence
    property p_reset_quiet;
        disable iff (1'b0) !nrst |-> sfr_rdata == 8'h00 && module_io_pin_out == 6'h00
            && module_io_pin_oe_n == 6'h3F && !irq_request;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared");
    property p_snapshot_hold;
        s_rd(8'hFA) ##1 s_rd(8'hFA) |=> sfr_rdata == $past(sfr_rdata);
    endproperty
    a_snapshot_hold: assert property (p_snapshot_hold) else $error("snapshot moved");
    property p_mode5_locked;
        s_rd(8'hCE) ##1 (s_wr(8'hCE) and watchdog_enable)
            ##1 s_rd(8'hCE) |=> sfr_rdata == $past(sfr_rdata, 2);
    endproperty
    a_mode5_locked: assert property (p_mode5_locked) else $error("locked mode changed");
    property p_low_clears;
        s_wr(8'hFB) ##1 s_rd(8'hDA) |=> !sfr_rdata[6];
    endproperty
    a_low_clears: assert property (p_low_clears) else $error("enable kept");
    property p_high_sets;
        s_wr(8'hFC) ##1 s_rd(8'hDA) |=> sfr_rdata[6];
    endproperty
    a_high_sets: assert property (p_high_sets) else $error("enable not set");
    property p_oe_on;
        s_wr(8'hDA) and sfr_wdata[2:1] != 2'b00 |=> !module_io_pin_oe_n[0];
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("pin not driven");
    property p_oe_off;
        s_wr(8'hDA) and sfr_wdata[2:1] == 2'b00 |=> module_io_pin_oe_n[0];
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin driven");
    property p_flag_sticky;
        s_rd(8'hD8) ##1 !sfr_we ##1 s_rd(8'hD8)
            |=> (sfr_rdata[5:0] & $past(sfr_rdata[5:0], 2)) == $past(sfr_rdata[5:0], 2);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
    property p_rdata_hold;
        !sfr_re |=> $stable(sfr_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule
bind counter_array counter_array_props i_props (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .count_tick(count_tick),
    .watchdog_enable(watchdog_enable), .module_io_pin_in(module_io_pin_in), .module_io_pin_out(module_io_pin_out),
    .module_io_pin_oe_n(module_io_pin_oe_n), .irq_request(irq_request));
`default_nettype wire

// ### sim/tb_counter_array.sv
// self-checking bench for the counter array register slice
// assumes capture_pins as far side and inputs changed at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_counter_array;
    logic        clk = 1'b0;
    logic        nrst;
    logic        sfr_we = 1'b0;
    logic        sfr_re = 1'b0;
    logic        count_tick = 1'b0;
    logic        watchdog_enable = 1'b0;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  sfr_rdata;
    logic [7:0]  d;
    logic [5:0]  level_req = 6'h00;
    logic [5:0]  pin_in;
    logic [5:0]  pin_out;
    logic [5:0]  oe_n;
    logic        irq;
    logic [31:0] seed = 32'h5EA44D87;
    logic [7:0]  md[6] = '{8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hCE};
    logic [7:0]  lo[6] = '{8'hFB, 8'hE9, 8'hEB, 8'hED, 8'hFD, 8'hD2};
    logic [7:0]  hi[6] = '{8'hFC, 8'hEA, 8'hEC, 8'hEE, 8'hFE, 8'hD3};
    logic [7:0]  cl[6];
    int          err_total = 0;
    int          n_compared = 0;
    int          ones;
    counter_array i_dut (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
        .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .count_tick(count_tick), .watchdog_enable(watchdog_enable),
        .module_io_pin_in(pin_in), .module_io_pin_out(pin_out), .module_io_pin_oe_n(oe_n), .irq_request(irq));
    capture_pins i_far (.clk(clk), .level_req(level_req), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_in(pin_in));
    initial begin
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [7:0] with_cmp(input logic [7:0] m, input logic on);
        with_cmp = m;
        with_cmp[6] = on;
    endfunction
    // strobes stay up so accesses run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        sfr_re = 1'b0;
        sfr_we = 1'b1;
        sfr_addr = a;
        sfr_wdata = v;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        sfr_we = 1'b0;
        sfr_re = 1'b1;
        sfr_addr = a;
        @(negedge clk);
        d = sfr_rdata;
    endtask
    task automatic idle(input int n);
        sfr_we = 1'b0;
        sfr_re = 1'b0;
        repeat (n) @(negedge clk);
    endtask
    task automatic tick(input int n);
        idle(0);
        count_tick = 1'b1;
        repeat (n) @(negedge clk);
        count_tick = 1'b0;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string what);
        rd(a);
        chk(what, exp, d);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #(20 * 40000);
        err_total++;
        stop_test();
    end
    initial begin
        logic [7:0] m;
        logic       p;
        nrst = 1'b0;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        for (int k = 0; k < 6; k++) begin
            rc(md[k], 8'h00, "mode");
            rc(lo[k], 8'h00, "cmp low");
            rc(hi[k], 8'h00, "cmp high");
        end
        rc(8'hF9, 8'h00, "count low");
        rc(8'hFA, 8'h00, "count high");
        rc(8'h00, 8'h00, "unmapped");
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            // no capture bits: pin edges would overwrite
            m = seed[7:0] & 8'hCF;
            cl[k] = seed[15:8];
            wr(md[k], m);
            rc(md[k], m, "mode");
            wr(lo[k], cl[k]);
            rc(md[k], with_cmp(m, 1'b0), "mode after low");
            wr(hi[k], ~cl[k]);
            rc(md[k], with_cmp(m, 1'b1), "mode after high");
            rc(lo[k], cl[k], "cmp low");
            rc(hi[k], ~cl[k], "cmp high");
        end
        wr(8'hDF, 8'h80);
        wr(8'hE9, 8'h5A);
        wr(8'hEA, 8'hA5);
        rc(8'hE9, 8'h5A, "reload low");
        rc(8'hEA, 8'hA5, "reload high");
        wr(8'hDF, 8'h00);
        rc(8'hE9, cl[1], "normal low");
        rc(8'hEA, ~cl[1], "normal high");
        for (int k = 0; k < 6; k++) wr(md[k], 8'h00);
        watchdog_enable = 1'b1;
        rd(8'hCE);
        wr(8'hCE, 8'h41);
        rc(8'hCE, 8'h00, "locked mode");
        wr(8'hF9, 8'h33);
        wr(8'hFA, 8'h44);
        rc(8'hF9, 8'h00, "locked count low");
        rc(8'hFA, 8'h00, "locked count high");
        watchdog_enable = 1'b0;
        wr(8'hCE, 8'h41);
        rc(8'hCE, 8'h41, "mode");
        wr(8'hF9, 8'h34);
        wr(8'hFA, 8'h77);
        rc(8'hF9, 8'h34, "count low");
        rc(8'hFA, 8'h77, "count high");
        wr(8'hFA, 8'h12);
        rc(8'hFA, 8'h77, "snapshot");
        rc(8'hFA, 8'h77, "snapshot");
        rc(8'hF9, 8'h34, "count low");
        rc(8'hFA, 8'h12, "snapshot");
        wr(8'hFB, 8'h35);
        wr(8'hFC, 8'h12);
        wr(8'hDA, 8'h4D);
        wr(8'hD8, 8'h40);
        p = pin_out[0];
        tick(1);
        idle(3);
        rc(8'hD8, 8'h41, "match flag");
        chk("irq", 8'h01, {7'h00, irq});
        idle(1);
        rc(8'hD8, 8'h41, "flag kept");
        chk("toggle pin", {7'h00, ~p}, {7'h00, pin_out[0]});
        chk("pin enable", 8'h00, {7'h00, oe_n[0]});
        wr(8'hDA, 8'h4C);
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(8'hD8, 8'h40);
        rc(8'hD8, 8'h40, "flag cleared");
        wr(8'hDC, 8'h20);
        level_req = 6'h04;
        idle(6);
        rc(8'hD8, 8'h44, "rise flag");
        rc(8'hEB, 8'h35, "rise value");
        wr(8'hDD, 8'h10);
        level_req = 6'h0C;
        idle(6);
        rc(8'hD8, 8'h44, "no rise capture");
        level_req = 6'h04;
        idle(6);
        rc(8'hD8, 8'h4C, "fall flag");
        rc(8'hED, 8'h35, "fall value");
        for (int c = 0; c < 4; c++) begin
            wr(8'hD8, 8'h00);
            wr(8'hF9, 8'h00);
            wr(8'hFA, 8'h00);
            wr(8'hDF, c[7:0]);
            wr(8'hD8, 8'h40);
            tick((1 << (8 + c)) - 1);
            idle(3);
            rc(8'hDF, c[7:0], "early overflow");
            tick(1);
            idle(3);
            rc(8'hDF, 8'h20 | c[7:0], "cycle overflow");
        end
        wr(8'hD8, 8'h00);
        wr(8'hDF, 8'h00);
        wr(8'hF9, 8'h00);
        wr(8'hFD, 8'h80);
        wr(8'hFE, 8'h80);
        wr(8'hDE, 8'h42);
        wr(8'hD8, 8'h40);
        tick(0);
        count_tick = 1'b1;
        ones = 0;
        repeat (512) begin
            @(negedge clk);
            ones += pin_out[4];
        end
        count_tick = 1'b0;
        chk("pwm duty", 8'h01, {7'h00, ones >= 250 && ones <= 262});
        chk("pwm enable", 8'h00, {7'h00, oe_n[4]});
        stop_test();
    end
endmodule
`default_nettype wire
